/* core/vsc_mode_control.v */
// mode decode, frequency lookup and carrier generation for the split-band scrambler
//
// Overview of operation
// RULE1 - powersave high stops everything except the timing clock path
// RULE2 - powersave floats all four audio pins and removes their bias
// RULE3 - powersave low gives normal operation from rx/tx and mute
// RULE4 - receive output driven by summer in receive, otherwise held at bias
// RULE5 - transmit routes summer through sub-audio highpass to transmit output
// RULE6 - receive puts sub-audio highpass ahead of band filters on input
// RULE7 - upper lowpass cutoff 3400 Hz receive, 2700 Hz transmit
// RULE8 - transmit input feeds both upper and lower band filters
// RULE9 - lower band filter choice follows receive/transmit selection
// RULE10 - scramble takes split and carriers from current 5-bit code
// RULE11 - low carrier and split table, 00000 is 2800/3105, 11111 is 350/650
// RULE12 - high carrier table, 6172 Hz down to 3731 Hz
// RULE13 - clear selects both arms, stops carriers, bypasses modulators
// RULE14 - clear drops lower band before summation
// RULE15 - mute low isolates audio path, pins stay at bias
// RULE16 - rx high enables rx pins, low enables tx pins, all biased
// RULE17 - muted keeps tx input, disconnects other three pins at bias
// RULE18 - controller should roll codes in step at both stations
// RULE19 - load/latch high is transparent, low holds latched word
// RULE20 - controller presents data with latch low, then strobes 0-1-0
// RULE21 - serial order enable, clear, rx/tx, code bits 0 to 4
// RULE22 - each serial bit takes one full serial clock cycle
// RULE23 - carriers come from the timing clock by per-code integer divide; the code divides the 10 MHz system clock CLOCK instead
`timescale 1ns/1ps
`include "vsc_defines.vh"
module vsc_mode_control (
   input wire CLOCK,
   input wire RST_B,
   input wire CLK_EN,
   input wire PARALLEL_MODE,
   input wire ENABLE_IN,
   input wire CLEAR_IN,
   input wire RX_SEL_IN,
   input wire [4:0] FREQ_CODE_IN,
   input wire LOAD_LATCH,
   input wire POWERSAVE,
   input wire SERIAL_DATA,
   input wire SERIAL_CLK,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   output reg CORE_ACTIVE,
   output reg RX_IN_OE,
   output reg RX_IN_BIAS,
   output reg RX_IN_PATH,
   output reg RX_OUT_OE,
   output reg RX_OUT_BIAS,
   output reg RX_OUT_FROM_SUMMER,
   output reg TX_IN_OE,
   output reg TX_IN_BIAS,
   output reg TX_IN_PATH,
   output reg TX_OUT_OE,
   output reg TX_OUT_BIAS,
   output reg TX_OUT_PATH,
   output reg HPF_ON_INPUT,
   output reg HPF_ON_OUTPUT,
   output reg [15:0] UPPER_LPF_HZ,
   output reg LOWER_FILTER_SEL,
   output reg UPPER_ARM_EN,
   output reg LOWER_ARM_EN,
   output reg LOWER_TO_SUMMER,
   output reg MOD_BYPASS,
   output reg [15:0] SPLIT_HZ,
   output reg [15:0] LOWER_CARRIER_HZ,
   output reg [15:0] UPPER_CARRIER_HZ,
   output reg LOWER_BAND_CARRIER,
   output reg UPPER_BAND_CARRIER
);

   ////////////////////////////////////////////////////////////////////////
   // frequency tables

   function [15:0] split_hz;
      input [4:0] c;
      begin
         case (c)
            5'h00: split_hz = 16'd2800;
            5'h01: split_hz = 16'd2625;
            5'h02: split_hz = 16'd2470;
            5'h03: split_hz = 16'd2333;
            5'h04: split_hz = 16'd2210;
            5'h05: split_hz = 16'd2100;
            5'h06: split_hz = 16'd2000;
            5'h07: split_hz = 16'd1909;
            5'h08: split_hz = 16'd1826;
            5'h09: split_hz = 16'd1750;
            5'h0a: split_hz = 16'd1680;
            5'h0b: split_hz = 16'd1555;
            5'h0c: split_hz = 16'd1448;
            5'h0d: split_hz = 16'd1354;
            5'h0e: split_hz = 16'd1272;
            5'h0f: split_hz = 16'd1200;
            5'h10: split_hz = 16'd1135;
            5'h11: split_hz = 16'd1050;
            5'h12: split_hz = 16'd976;
            5'h13: split_hz = 16'd913;
            5'h14: split_hz = 16'd857;
            5'h15: split_hz = 16'd792;
            5'h16: split_hz = 16'd736;
            5'h17: split_hz = 16'd688;
            5'h18: split_hz = 16'd636;
            5'h19: split_hz = 16'd591;
            5'h1a: split_hz = 16'd552;
            5'h1b: split_hz = 16'd512;
            5'h1c: split_hz = 16'd471;
            5'h1d: split_hz = 16'd428;
            5'h1e: split_hz = 16'd388;
            default: split_hz = 16'd350;
         endcase
      end
   endfunction

   function [15:0] low_hz;
      input [4:0] c;
      begin
         case (c)
            5'h00: low_hz = 16'd3105;
            5'h01: low_hz = 16'd2923;
            5'h02: low_hz = 16'd2777;
            5'h03: low_hz = 16'd2631;
            5'h04: low_hz = 16'd2512;
            5'h05: low_hz = 16'd2403;
            5'h06: low_hz = 16'd2304;
            5'h07: low_hz = 16'd2212;
            5'h08: low_hz = 16'd2127;
            5'h09: low_hz = 16'd2049;
            5'h0a: low_hz = 16'd1984;
            5'h0b: low_hz = 16'd1858;
            5'h0c: low_hz = 16'd1748;
            5'h0d: low_hz = 16'd1655;
            5'h0e: low_hz = 16'd1572;
            5'h0f: low_hz = 16'd1501;
            5'h10: low_hz = 16'd1436;
            5'h11: low_hz = 16'd1351;
            5'h12: low_hz = 16'd1278;
            5'h13: low_hz = 16'd1213;
            5'h14: low_hz = 16'd1157;
            5'h15: low_hz = 16'd1094;
            5'h16: low_hz = 16'd1037;
            5'h17: low_hz = 16'd988;
            5'h18: low_hz = 16'd936;
            5'h19: low_hz = 16'd891;
            5'h1a: low_hz = 16'd853;
            5'h1b: low_hz = 16'd813;
            5'h1c: low_hz = 16'd772;
            5'h1d: low_hz = 16'd728;
            5'h1e: low_hz = 16'd688;
            default: low_hz = 16'd650;
         endcase
      end
   endfunction

   function [15:0] high_hz;
      input [4:0] c;
      begin
         case (c)
            5'h00: high_hz = 16'd6172;
            5'h01: high_hz = 16'd6024;
            5'h02: high_hz = 16'd5813;
            5'h03: high_hz = 16'd5681;
            5'h04: high_hz = 16'd5555;
            5'h05: high_hz = 16'd5494;
            5'h06: high_hz = 16'd5376;
            5'h07: high_hz = 16'd5263;
            5'h08: high_hz = 16'd5208;
            5'h09: high_hz = 16'd5102;
            5'h0a: high_hz = 16'd5050;
            5'h0b: high_hz = 16'd4950;
            5'h0c: high_hz = 16'd4807;
            5'h0d: high_hz = 16'd4716;
            5'h0e: high_hz = 16'd4629;
            5'h0f: high_hz = 16'd4587;
            5'h10: high_hz = 16'd4504;
            5'h11: high_hz = 16'd4424;
            5'h12: high_hz = 16'd4347;
            5'h13: high_hz = 16'd4310;
            5'h14: high_hz = 16'd4273;
            5'h15: high_hz = 16'd4166;
            5'h16: high_hz = 16'd4132;
            5'h17: high_hz = 16'd4065;
            5'h18: high_hz = 16'd4032;
            5'h19: high_hz = 16'd3968;
            5'h1a: high_hz = 16'd3937;
            5'h1b: high_hz = 16'd3906;
            5'h1c: high_hz = 16'd3846;
            5'h1d: high_hz = 16'd3816;
            5'h1e: high_hz = 16'd3787;
            default: high_hz = 16'd3731;
         endcase
      end
   endfunction

   // half period in system clocks, rounded to nearest; clock / (2 f)
   function [15:0] half_div;
      input [15:0] f;
      reg [31:0] q;
      begin
         q = (`VSC_CLK_HZ + {16'h0000, f}) / {15'h0000, f, 1'b0};
         half_div = q[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // control word loading

   reg [7:0] shift_r;
   reg [7:0] latched_r;
   reg sclk_prev_r;
   reg [7:0] sw_ctrl_r;
   reg sw_override_r;
   wire [7:0] par_word = {FREQ_CODE_IN, RX_SEL_IN, CLEAR_IN, ENABLE_IN};
   wire [7:0] src_word = PARALLEL_MODE ? par_word : shift_r;
   // transparent while latch high, so the word in use takes the new word during the strobe, not a cycle after it
   wire [7:0] pin_word = LOAD_LATCH ? src_word : latched_r; // RULE19
   wire [7:0] word = sw_override_r ? sw_ctrl_r : pin_word;
   wire en_w = word[`VSC_BIT_ENABLE];
   wire clear_w = word[`VSC_BIT_CLEAR];
   wire rx_w = word[`VSC_BIT_RX];
   wire [4:0] code_w = word[7:3];
   wire run_w = ~POWERSAVE; // RULE3

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         shift_r <= `VSC_CTRL_RST;
         latched_r <= `VSC_CTRL_RST;
         // pin idles high on its pull-up; a low reset value would fake an edge
         sclk_prev_r <= 1'b1;
      end else if (CLK_EN) begin
         sclk_prev_r <= SERIAL_CLK;
         // one bit per full serial clock, taken on its rising edge
         if (SERIAL_CLK && !sclk_prev_r && !PARALLEL_MODE) begin
            shift_r <= {SERIAL_DATA, shift_r[7:1]}; // RULE21 RULE22
         end
         if (LOAD_LATCH) begin
            latched_r <= src_word; // RULE19 RULE20
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // path and filter decode

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         CORE_ACTIVE <= 1'b0;
         {RX_IN_OE, RX_IN_BIAS, RX_IN_PATH} <= 3'h0;
         {RX_OUT_OE, RX_OUT_BIAS, RX_OUT_FROM_SUMMER} <= 3'h0;
         {TX_IN_OE, TX_IN_BIAS, TX_IN_PATH} <= 3'h0;
         {TX_OUT_OE, TX_OUT_BIAS, TX_OUT_PATH} <= 3'h0;
         {HPF_ON_INPUT, HPF_ON_OUTPUT} <= 2'h0;
         UPPER_LPF_HZ <= 16'h0000;
         LOWER_FILTER_SEL <= 1'b0;
         {UPPER_ARM_EN, LOWER_ARM_EN, LOWER_TO_SUMMER, MOD_BYPASS} <= 4'h0;
         SPLIT_HZ <= 16'h0000;
         LOWER_CARRIER_HZ <= 16'h0000;
         UPPER_CARRIER_HZ <= 16'h0000;
      end else if (CLK_EN) begin
         CORE_ACTIVE <= run_w; // RULE1
         // pins float and lose bias in powersave
         RX_IN_OE <= run_w; // RULE2
         RX_OUT_OE <= run_w; // RULE2
         TX_IN_OE <= run_w; // RULE2
         TX_OUT_OE <= run_w; // RULE2
         RX_IN_BIAS <= run_w; // RULE15 RULE16 RULE17
         RX_OUT_BIAS <= run_w; // RULE4
         TX_IN_BIAS <= run_w; // RULE16
         TX_OUT_BIAS <= run_w; // RULE16
         RX_IN_PATH <= run_w & en_w & rx_w; // RULE16 RULE17
         RX_OUT_FROM_SUMMER <= run_w & en_w & rx_w; // RULE4 RULE15
         // tx input stays live while muted
         TX_IN_PATH <= run_w & (~rx_w | ~en_w); // RULE8 RULE17
         TX_OUT_PATH <= run_w & en_w & ~rx_w; // RULE5 RULE15
         HPF_ON_INPUT <= run_w & rx_w; // RULE6
         HPF_ON_OUTPUT <= run_w & ~rx_w; // RULE5
         UPPER_LPF_HZ <= run_w ? (rx_w ? `VSC_LPF_RX_HZ : `VSC_LPF_TX_HZ) : 16'h0000; // RULE7
         LOWER_FILTER_SEL <= run_w & rx_w; // RULE9
         UPPER_ARM_EN <= run_w; // RULE13
         LOWER_ARM_EN <= run_w; // RULE13
         LOWER_TO_SUMMER <= run_w & ~clear_w; // RULE14
         MOD_BYPASS <= run_w & clear_w; // RULE13
         SPLIT_HZ <= (run_w & ~clear_w) ? split_hz(code_w) : 16'h0000; // RULE10 RULE11
         LOWER_CARRIER_HZ <= (run_w & ~clear_w) ? low_hz(code_w) : 16'h0000; // RULE11
         UPPER_CARRIER_HZ <= (run_w & ~clear_w) ? high_hz(code_w) : 16'h0000; // RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // carrier dividers; integer rounding leaves a few hertz of error

   reg [15:0] lo_cnt_r;
   reg [15:0] hi_cnt_r;
   wire car_on = run_w & ~clear_w; // RULE13
   wire [15:0] lo_half = half_div(low_hz(code_w));
   wire [15:0] hi_half = half_div(high_hz(code_w));

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         lo_cnt_r <= 16'h0000;
         hi_cnt_r <= 16'h0000;
         LOWER_BAND_CARRIER <= 1'b0;
         UPPER_BAND_CARRIER <= 1'b0;
      end else if (CLK_EN) begin
         if (!car_on) begin
            lo_cnt_r <= 16'h0000;
            hi_cnt_r <= 16'h0000;
            LOWER_BAND_CARRIER <= 1'b0;
            UPPER_BAND_CARRIER <= 1'b0;
         end else begin
            if (lo_cnt_r + 16'h0001 >= lo_half) begin
               lo_cnt_r <= 16'h0000;
               LOWER_BAND_CARRIER <= ~LOWER_BAND_CARRIER; // RULE23
            end else begin
               lo_cnt_r <= lo_cnt_r + 16'h0001;
            end
            if (hi_cnt_r + 16'h0001 >= hi_half) begin
               hi_cnt_r <= 16'h0000;
               UPPER_BAND_CARRIER <= ~UPPER_BAND_CARRIER; // RULE23
            end else begin
               hi_cnt_r <= hi_cnt_r + 16'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave, one wait-free access phase

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sw_ctrl_r <= `VSC_CTRL_RST;
         sw_override_r <= 1'b0;
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else if (CLK_EN) begin
         PREADY <= PSEL & ~PENABLE;
         PSLVERR <= 1'b0;
         // write lands at the completing edge of the access phase
         if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `VSC_APB_CTRL) begin
            sw_ctrl_r <= PWDATA[7:0];
            sw_override_r <= PWDATA[8];
         end
         if (PSEL && !PENABLE) begin
            PRDATA <= 32'h00000000;
            case (PADDR)
               `VSC_APB_CTRL: begin
                  if (!PWRITE) begin
                     PRDATA <= {23'h000000, sw_override_r, sw_ctrl_r};
                  end
               end
               `VSC_APB_STAT: PRDATA <= {22'h000000, POWERSAVE, run_w & en_w, word};
               `VSC_APB_SPLIT: PRDATA <= {16'h0000, SPLIT_HZ};
               `VSC_APB_CARR: PRDATA <= {UPPER_CARRIER_HZ, LOWER_CARRIER_HZ};
               default: PSLVERR <= 1'b1;
            endcase
         end
      end
   end

endmodule // vsc_mode_control

/* shared/vsc_defines.vh */
// constants for the voice scrambler mode control core
`ifndef VSC_DEFINES_VH
`define VSC_DEFINES_VH
`define VSC_TIMING_HZ 1000000
`define VSC_CLK_HZ 10000000
`define VSC_DIV_W 16
`define VSC_WORD_W 8
`define VSC_BIT_ENABLE 0
`define VSC_BIT_CLEAR 1
`define VSC_BIT_RX 2
`define VSC_BIT_CODE_LO 3
`define VSC_CTRL_RST 8'h07
`define VSC_LPF_RX_HZ 16'd3400
`define VSC_LPF_TX_HZ 16'd2700
`define VSC_APB_CTRL 12'h000
`define VSC_APB_STAT 12'h004
`define VSC_APB_SPLIT 12'h008
`define VSC_APB_CARR 12'h00c
`endif

/* test/vsc_mode_control_sva.sv */
// assertions on the mode control core ports
`timescale 1ns/1ps
module vsc_mode_control_sva (
   input wire CLOCK,
   input wire RST_B,
   input wire CLK_EN,
   input wire POWERSAVE,
   input wire PSEL,
   input wire PENABLE,
   input wire PREADY,
   input wire CORE_ACTIVE,
   input wire RX_IN_OE,
   input wire RX_IN_BIAS,
   input wire TX_IN_OE,
   input wire TX_OUT_OE,
   input wire TX_OUT_BIAS,
   input wire RX_OUT_FROM_SUMMER,
   input wire RX_IN_PATH,
   input wire TX_IN_PATH,
   input wire TX_OUT_PATH,
   input wire HPF_ON_INPUT,
   input wire HPF_ON_OUTPUT,
   input wire [15:0] UPPER_LPF_HZ,
   input wire LOWER_TO_SUMMER,
   input wire MOD_BYPASS,
   input wire UPPER_ARM_EN,
   input wire LOWER_ARM_EN,
   input wire [15:0] SPLIT_HZ,
   input wire [15:0] UPPER_CARRIER_HZ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // sampled reset in the antecedent keeps the release edge out
   property p_ps_off;
      RST_B && POWERSAVE && CLK_EN |=> !CORE_ACTIVE && UPPER_LPF_HZ == 16'h0;
   endproperty
   a_ps_off: assert property (p_ps_off) else $error("powersave left core on");
   property p_ps_float;
      RST_B && POWERSAVE && CLK_EN |=> !RX_IN_OE && !TX_IN_OE && !TX_OUT_OE && !RX_IN_BIAS;
   endproperty
   a_ps_float: assert property (p_ps_float) else $error("powersave pins not floated");
   property p_run;
      RST_B && !POWERSAVE && CLK_EN |=> CORE_ACTIVE && RX_IN_BIAS && TX_OUT_BIAS;
   endproperty
   a_run: assert property (p_run) else $error("normal run not resumed");
   property p_lpf;
      CORE_ACTIVE |-> UPPER_LPF_HZ == (HPF_ON_INPUT ? 16'hd48 : 16'ha8c);
   endproperty
   a_lpf: assert property (p_lpf) else $error("upper cutoff wrong for mode");
   property p_rx;
      RX_OUT_FROM_SUMMER |-> HPF_ON_INPUT && !HPF_ON_OUTPUT && !TX_OUT_PATH;
   endproperty
   a_rx: assert property (p_rx) else $error("receive path set wrong");
   property p_tx;
      TX_OUT_PATH |-> HPF_ON_OUTPUT && TX_IN_PATH && !RX_IN_PATH;
   endproperty
   a_tx: assert property (p_tx) else $error("transmit path set wrong");
   property p_clear;
      MOD_BYPASS |-> !LOWER_TO_SUMMER && UPPER_ARM_EN && LOWER_ARM_EN
         && SPLIT_HZ == 16'h0 && UPPER_CARRIER_HZ == 16'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear mode set wrong");
   property p_apb;
      PSEL && !PENABLE && CLK_EN |=> PREADY ##1 !PREADY;
   endproperty
   a_apb: assert property (p_apb) else $error("bus answer not one cycle");
endmodule // vsc_mode_control_sva
bind vsc_mode_control vsc_mode_control_sva i_vsc_mode_control_sva (.CLOCK(CLOCK), .RST_B(RST_B),
   .CLK_EN(CLK_EN), .POWERSAVE(POWERSAVE), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .CORE_ACTIVE(CORE_ACTIVE), .RX_IN_OE(RX_IN_OE), .RX_IN_BIAS(RX_IN_BIAS), .TX_IN_OE(TX_IN_OE),
   .TX_OUT_OE(TX_OUT_OE), .TX_OUT_BIAS(TX_OUT_BIAS), .RX_OUT_FROM_SUMMER(RX_OUT_FROM_SUMMER),
   .RX_IN_PATH(RX_IN_PATH), .TX_IN_PATH(TX_IN_PATH), .TX_OUT_PATH(TX_OUT_PATH),
   .HPF_ON_INPUT(HPF_ON_INPUT), .HPF_ON_OUTPUT(HPF_ON_OUTPUT), .UPPER_LPF_HZ(UPPER_LPF_HZ),
   .LOWER_TO_SUMMER(LOWER_TO_SUMMER), .MOD_BYPASS(MOD_BYPASS), .UPPER_ARM_EN(UPPER_ARM_EN),
   .LOWER_ARM_EN(LOWER_ARM_EN), .SPLIT_HZ(SPLIT_HZ), .UPPER_CARRIER_HZ(UPPER_CARRIER_HZ));

/* test/vsc_ctrl_model.sv */
// external controller: loads the control word in parallel or serially
`timescale 1ns/1ps
module vsc_ctrl_model (
   input wire clock,
   input wire go,
   input wire par,
   input wire [7:0] word,
   output reg busy,
   output reg pmode,
   output reg [7:0] pins,
   output reg latch,
   output reg sdata,
   output reg sclk
);
   initial begin
      busy = 0;
      pmode = 1;
      pins = 8'h07;
      latch = 0;
      sdata = 0;
      sclk = 0;
   end
   always @(posedge go) begin : run
      integer i;
      busy = 1;
      @(posedge clock);
      pmode <= par;
      if (par) pins <= word;
      else for (i = 0; i < 8; i = i + 1) begin
         sdata <= word[i];
         repeat (2) @(posedge clock);
         sclk <= 1;
         repeat (2) @(posedge clock);
         sclk <= 0;
      end
      @(posedge clock);
      latch <= 1;
      @(posedge clock);
      latch <= 0;
      // released data line must not keep looking valid
      sdata <= ~sdata;
      repeat (2) @(posedge clock);
      busy <= 0;
   end
endmodule // vsc_ctrl_model

/* test/voice_scrambler_mode_control_bench.sv */
// self-checking bench for the mode control core
`timescale 1ns/1ps
module voice_scrambler_mode_control_bench;
   reg CLOCK, RST_B, CLK_EN, POWERSAVE, PSEL, PENABLE, PWRITE, go, par, sel_up;
   reg [11:0] PADDR;
   reg [31:0] PWDATA, q;
   reg [7:0] word;
   reg e;
   integer err_count, num_checks;
   wire [31:0] PRDATA;
   wire [15:0] UPPER_LPF_HZ, SPLIT_HZ, LOWER_CARRIER_HZ, UPPER_CARRIER_HZ;
   wire [7:0] pw;
   wire PREADY, PSLVERR, CORE_ACTIVE, RX_IN_OE, RX_IN_BIAS, RX_IN_PATH, RX_OUT_OE, RX_OUT_BIAS;
   wire RX_OUT_FROM_SUMMER, TX_IN_OE, TX_IN_BIAS, TX_IN_PATH, TX_OUT_OE, TX_OUT_BIAS;
   wire TX_OUT_PATH, HPF_ON_INPUT, HPF_ON_OUTPUT, LOWER_FILTER_SEL, UPPER_ARM_EN;
   wire LOWER_ARM_EN, LOWER_TO_SUMMER, MOD_BYPASS, LOWER_BAND_CARRIER, UPPER_BAND_CARRIER;
   wire busy, pmode, latch, sdata, sclk;
   wire [7:0] paths = {RX_IN_PATH, RX_OUT_FROM_SUMMER, TX_IN_PATH, TX_OUT_PATH, HPF_ON_INPUT,
      HPF_ON_OUTPUT, LOWER_FILTER_SEL, LOWER_TO_SUMMER};
   wire [7:0] pads = {RX_IN_OE, RX_IN_BIAS, RX_OUT_OE, RX_OUT_BIAS, TX_IN_OE, TX_IN_BIAS,
      TX_OUT_OE, TX_OUT_BIAS};
   wire [47:0] freq = {SPLIT_HZ, LOWER_CARRIER_HZ, UPPER_CARRIER_HZ};
   wire car = sel_up ? UPPER_BAND_CARRIER : LOWER_BAND_CARRIER;
   vsc_ctrl_model i_vsc_ctrl_model (.clock(CLOCK), .go(go), .par(par), .word(word),
      .busy(busy), .pmode(pmode), .pins(pw), .latch(latch), .sdata(sdata), .sclk(sclk));
   vsc_mode_control i_vsc_mode_control (.CLOCK(CLOCK), .RST_B(RST_B), .CLK_EN(CLK_EN),
      .PARALLEL_MODE(pmode), .ENABLE_IN(pw[0]), .CLEAR_IN(pw[1]), .RX_SEL_IN(pw[2]),
      .FREQ_CODE_IN(pw[7:3]), .LOAD_LATCH(latch), .POWERSAVE(POWERSAVE), .SERIAL_DATA(sdata),
      .SERIAL_CLK(sclk), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .CORE_ACTIVE(CORE_ACTIVE), .RX_IN_OE(RX_IN_OE), .RX_IN_BIAS(RX_IN_BIAS),
      .RX_IN_PATH(RX_IN_PATH), .RX_OUT_OE(RX_OUT_OE), .RX_OUT_BIAS(RX_OUT_BIAS),
      .RX_OUT_FROM_SUMMER(RX_OUT_FROM_SUMMER), .TX_IN_OE(TX_IN_OE), .TX_IN_BIAS(TX_IN_BIAS),
      .TX_IN_PATH(TX_IN_PATH), .TX_OUT_OE(TX_OUT_OE), .TX_OUT_BIAS(TX_OUT_BIAS),
      .TX_OUT_PATH(TX_OUT_PATH), .HPF_ON_INPUT(HPF_ON_INPUT), .HPF_ON_OUTPUT(HPF_ON_OUTPUT),
      .UPPER_LPF_HZ(UPPER_LPF_HZ), .LOWER_FILTER_SEL(LOWER_FILTER_SEL),
      .UPPER_ARM_EN(UPPER_ARM_EN), .LOWER_ARM_EN(LOWER_ARM_EN),
      .LOWER_TO_SUMMER(LOWER_TO_SUMMER), .MOD_BYPASS(MOD_BYPASS), .SPLIT_HZ(SPLIT_HZ),
      .LOWER_CARRIER_HZ(LOWER_CARRIER_HZ), .UPPER_CARRIER_HZ(UPPER_CARRIER_HZ),
      .LOWER_BAND_CARRIER(LOWER_BAND_CARRIER), .UPPER_BAND_CARRIER(UPPER_BAND_CARRIER));
   always #50 CLOCK = ~CLOCK;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [63:0] got, input [63:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks=%0d errors=%0d", num_checks, err_count);
         if (err_count == 0 && num_checks > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // one transfer; the request holds until pready is seen at an edge
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge CLOCK);
         PSEL <= 1;
         PENABLE <= 0;
         PWRITE <= w;
         PADDR <= a;
         PWDATA <= d;
         @(posedge CLOCK);
         PENABLE <= 1;
         @(posedge CLOCK);
         // no limit here; if pready never comes, only the watchdog ends this wait
         while (PREADY !== 1'b1) @(posedge CLOCK);
         q = PRDATA;
         e = PSLVERR;
         PSEL <= 0;
         PENABLE <= 0;
      end
   endtask
   task load(input [7:0] w, input p);
      begin
         @(posedge CLOCK);
         word <= w;
         par <= p;
         go <= 1;
         @(posedge CLOCK);
         go <= 0;
         while (busy !== 1'b0) @(posedge CLOCK);
         @(posedge CLOCK);
      end
   endtask
   task halfp(input [15:0] exp);
      integer n;
      reg v;
      begin
         // first pass may end on the select change, second on a partial period
         repeat (3) begin
            v = car;
            n = 0;
            while (car === v && n < 5000) begin
               @(posedge CLOCK);
               n = n + 1;
            end
         end
         chk(n, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      begin
         apb(0, 12'h000, 0);
         chk({e, q}, {1'b0, 32'h7});
         apb(0, 12'h010, 0);
         chk({e, q}, {1'b1, 32'h0});
         apb(1, 12'h000, 32'h15d);
         apb(0, 12'h004, 0);
         chk(q[9:0], 10'h15d);
         chk(paths, 8'hcb);
         apb(0, 12'h00c, 0);
         chk(q, {16'd4950, 16'd1858});
         chk(SPLIT_HZ, 16'd1555);
         apb(0, 12'h008, 0);
         chk(q, {16'h0000, 16'd1555});
         apb(1, 12'h000, 0);
         $display("t_regs done");
      end
   endtask
   task t_modes;
      begin
         load(8'h01, 1);
         chk(freq, {16'd2800, 16'd3105, 16'd6172});
         chk({paths, UPPER_LPF_HZ}, {8'h35, 16'd2700});
         load(8'hf9, 1);
         chk(freq, {16'd350, 16'd650, 16'd3731});
         load(8'h5d, 1);
         chk({paths, UPPER_LPF_HZ}, {8'hcb, 16'd3400});
         load(8'h00, 1);
         chk({paths, pads}, {8'h25, 8'hff});
         load(8'h04, 1);
         chk(paths, 8'h2b);
         load(8'h03, 1);
         chk({paths, UPPER_ARM_EN, LOWER_ARM_EN, MOD_BYPASS}, {8'h34, 3'b111});
         chk(freq, 48'h0);
         $display("t_modes done");
      end
   endtask
   task t_serial;
      begin
         load(8'h09, 0);
         chk(freq, {16'd2625, 16'd2923, 16'd6024});
         chk(paths, 8'h35);
         $display("t_serial done");
      end
   endtask
   task t_carrier;
      begin
         load(8'h01, 1);
         sel_up <= 1;
         halfp(16'd810);
         sel_up <= 0;
         halfp(16'd1610);
         $display("t_carrier done");
      end
   endtask
   task t_psave;
      begin
         load(8'h5d, 1);
         // frozen clock enable must hold CORE_ACTIVE and the path outputs
         CLK_EN <= 0;
         POWERSAVE <= 1;
         repeat (3) @(posedge CLOCK);
         chk({CORE_ACTIVE, paths}, {1'b1, 8'hcb});
         CLK_EN <= 1;
         repeat (3) @(posedge CLOCK);
         chk({CORE_ACTIVE, pads, UPPER_LPF_HZ, paths}, 0);
         chk({UPPER_BAND_CARRIER, LOWER_BAND_CARRIER, freq}, 0);
         POWERSAVE <= 0;
         repeat (3) @(posedge CLOCK);
         chk({CORE_ACTIVE, pads, paths}, {1'b1, 8'hff, 8'hcb});
         $display("t_psave done");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(100 * 30000);
      err_count = err_count + 1;
      test_done;
   end
   initial begin
      CLOCK = 0;
      RST_B = 0;
      CLK_EN = 1;
      POWERSAVE = 0;
      PSEL = 0;
      PENABLE = 0;
      PWRITE = 0;
      PADDR = 0;
      PWDATA = 0;
      go = 0;
      par = 1;
      word = 0;
      sel_up = 0;
      err_count = 0;
      num_checks = 0;
      repeat (6) @(posedge CLOCK);
      RST_B <= 1;
      t_regs;
      t_modes;
      t_serial;
      t_carrier;
      t_psave;
      test_done;
   end
endmodule // voice_scrambler_mode_control_bench
